// ==== core/swc_pkg.sv ====
/*
  Constants and types shared by the sleep and wake-up controller and its start-up timer.
  Assumes a 100 MHz system clock and an APB register port with 32-bit data.
*/
package swc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB port.
  localparam logic [7:0] SWC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWC_STATUS_OFS = 8'h04;

  // Control register fields.
  localparam int SWC_CTRL_W = 9;
  localparam int SWC_C_WDT_EN = 0;
  localparam int SWC_C_GIE = 1;
  localparam int SWC_C_EDGE_EN = 2;
  localparam int SWC_C_PINCHG_EN = 3;
  localparam int SWC_C_AD_EN = 4;
  localparam int SWC_C_AD_RC = 5;
  localparam int SWC_C_OSC_LSB = 6;
  localparam logic [SWC_CTRL_W-1:0] SWC_CTRL_RESET = 9'h000;

  // Status register fields.
  localparam int SWC_S_ASLEEP = 0;
  localparam int SWC_S_OST_BUSY = 1;
  localparam int SWC_S_PD = 3;
  localparam int SWC_S_TO = 4;
  localparam int SWC_S_CAUSE_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator modes held in the control register.
  localparam logic [2:0] SWC_INTERNAL_RC_OSC_MODE = 3'h0;
  localparam logic [2:0] SWC_EXTERNAL_RC_OSC_MODE = 3'h1;
  localparam logic [2:0] SWC_CRYSTAL_OSC_MODE = 3'h2;
  localparam logic [2:0] SWC_FAST_CRYSTAL_OSC_MODE = 3'h3;
  localparam logic [2:0] SWC_LOW_POWER_CRYSTAL_MODE = 3'h4;

  // Last wake or reset cause.
  localparam logic [2:0] SWC_CAUSE_NONE = 3'h0;
  localparam logic [2:0] SWC_CAUSE_MASTER_CLEAR_PIN = 3'h1;
  localparam logic [2:0] SWC_CAUSE_WDT = 3'h2;
  localparam logic [2:0] SWC_CAUSE_IRQ = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator start-up time, in oscillator periods; one period is one system clock.
  localparam int SWC_CLK_PERIOD_NS = 10;
  localparam int SWC_TOSC_NS = 10;
  localparam int SWC_OST_TOSC = 1024;
  localparam int SWC_OST_CYCLES =
    (SWC_OST_TOSC * SWC_TOSC_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SWC_RUN = 4'b0001,
    SWC_SLEEP = 4'b0010,
    SWC_OSTW = 4'b0100,
    SWC_RESUME = 4'b1000
  } swc_state_t;

endpackage

// ==== core/swc_startup_timer.sv ====
/*
  Oscillator start-up timer: counts a fixed number of clocks after a start pulse.
  Assumes start is a one-cycle pulse from a register and is not repeated while busy.
*/
`timescale 1ns/1ns
`default_nettype none

module swc_startup_timer
  import swc_pkg::*;
#(
  parameter int unsigned CYCLES = SWC_OST_CYCLES
) (
  input wire logic CLK,     // System clock.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic start,   // Begin a start-up delay.
  output logic done,        // One-cycle pulse when the delay has run out.
  output logic busy         // High while the delay runs.
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("Start-up delay must be at least one cycle.");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } swc_ost_t;

  swc_ost_t r, n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (r.busy) begin
      if (r.cnt == '0) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - W'(1);
      end
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt = LOAD;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
  assign busy = r.busy;

  a_done_after_busy: assert property (@(posedge CLK) disable iff (SYS_RST)
    done |-> $past(busy) && !busy)
    else $error("Start-up done pulse without a running delay.");

endmodule

`default_nettype wire

// ==== core/swc_sleep_ctrl.sv ====
/*
  Sleep and wake-up controller of a small microcontroller core, with an APB register port.
  Assumes the core gives one-cycle pulses for the sleep instruction and the watchdog
  time-out, and level interrupt flags that stay set until software clears them.
*/
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module swc_sleep_ctrl
  import swc_pkg::*;
#(
  parameter int unsigned OST_CYCLES = SWC_OST_CYCLES
) (
  input wire logic CLK,                 // System clock, 100 MHz.
  input wire logic SYS_RST,             // Synchronous reset, active high.
  input wire logic PSEL,                // APB select.
  input wire logic PENABLE,             // APB access phase.
  input wire logic PWRITE,              // APB direction, high for write.
  input wire logic [7:0] PADDR,         // APB byte address.
  input wire logic [31:0] PWDATA,       // APB write data.
  output logic [31:0] PRDATA,           // APB read data.
  output logic PREADY,                  // APB ready.
  output logic PSLVERR,                 // APB error on unmapped address.
  input wire logic SLEEP_EXEC,          // Pulse: core executes the sleep instruction.
  input wire logic MASTER_CLEAR_PIN_N,  // External reset pin, active low.
  input wire logic WDT_TIMEOUT,         // Pulse: watchdog timer has run out.
  input wire logic EDGE_IRQ_FLAG,       // Edge interrupt flag.
  input wire logic PINCHG_IRQ_FLAG,     // Pin-change interrupt flag.
  input wire logic AD_IRQ_FLAG,         // A/D conversion done flag.
  output logic OSC_RUN,                 // Main oscillator driver on.
  output logic PHASE_CLK_RUN,           // Core phase clocks running.
  output logic PIN_HOLD,                // Freeze pin drive states.
  output logic WDT_CLEAR,               // Pulse: clear watchdog and postscaler.
  output logic DEVICE_RESET,            // Pulse: full device reset.
  output logic PREFETCH_REQ,            // Pulse: fetch the instruction after sleep.
  output logic RESUME_EXEC,             // Pulse: execute the prefetched instruction.
  output logic VECTOR_BRANCH,           // Pulse: branch to the interrupt vector after it.
  output logic POWER_DOWN_FLAG,         // Status power-down flag.
  output logic TIMEOUT_FLAG             // Status time-out flag.
);

  if (OST_CYCLES < 1) begin : g_bad_ost
    $error("Start-up delay must be at least one cycle.");
  end

  // Wide enough to count past the whole start-up wait without wrapping.
  localparam int WAIT_W = $clog2(OST_CYCLES + 3) + 1;

  typedef struct packed {
    swc_state_t st;
    logic [SWC_CTRL_W-1:0] ctrl;
    logic pd;
    logic to;
    logic [2:0] cause;
    logic vec;
    logic edge_en_lat;
    logic [2:0] flags_prev;
    logic ost_start;
    logic osc_run;
    logic phase_run;
    logic pin_hold;
    logic wdt_clear;
    logic dev_reset;
    logic prefetch;
    logic resume;
    logic vector_br;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [WAIT_W-1:0] ost_wait;
  } swc_ctl_t;

  swc_ctl_t r, n;
  logic ost_done;
  logic ost_busy;

  // Wake condition of the interrupt sources; phase-clocked peripherals have no input here.
  function automatic logic irq_wake(input logic [2:0] flags, input logic [SWC_CTRL_W-1:0] c,
                                    input logic edge_en);
    irq_wake = (flags[0] & edge_en) |
               (flags[1] & c[SWC_C_PINCHG_EN]) |
               (flags[2] & c[SWC_C_AD_EN] & c[SWC_C_AD_RC]);
  endfunction

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == SWC_CRYSTAL_OSC_MODE) || (mode == SWC_FAST_CRYSTAL_OSC_MODE) ||
                 (mode == SWC_LOW_POWER_CRYSTAL_MODE);
  endfunction

  logic [2:0] flags_now;
  logic wdt_en;
  logic [2:0] osc_mode;
  logic apb_access;

  assign flags_now = {AD_IRQ_FLAG, PINCHG_IRQ_FLAG, EDGE_IRQ_FLAG};
  assign wdt_en = r.ctrl[SWC_C_WDT_EN];
  assign osc_mode = r.ctrl[SWC_C_OSC_LSB +: 3];
  assign apb_access = PSEL && PENABLE;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.wdt_clear = 1'b0;
    n.dev_reset = 1'b0;
    n.prefetch = 1'b0;
    n.resume = 1'b0;
    n.vector_br = 1'b0;
    n.ost_start = 1'b0;
    n.flags_prev = flags_now;

    // Cycles spent waiting on the start-up timer; it saturates so a hang stays visible.
    if (r.st != SWC_OSTW) begin
      n.ost_wait = '0;
    end else if (!(&r.ost_wait)) begin
      n.ost_wait = r.ost_wait + WAIT_W'(1);
    end

    // APB slave: one wait state; a write lands on the edge that samples PREADY high.
    n.pready = apb_access && !r.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (apb_access) begin
      if (PADDR == SWC_CTRL_OFS) begin
        if (PWRITE && r.pready) begin
          n.ctrl = PWDATA[SWC_CTRL_W-1:0];
        end
        n.prdata = {23'h00_0000, r.ctrl};
      end else if (PADDR == SWC_STATUS_OFS) begin
        n.prdata[SWC_S_ASLEEP] = (r.st != SWC_RUN);
        n.prdata[SWC_S_OST_BUSY] = ost_busy;
        n.prdata[SWC_S_PD] = r.pd;
        n.prdata[SWC_S_TO] = r.to;
        n.prdata[SWC_S_CAUSE_LSB +: 3] = r.cause;
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // The pin is trusted to stay high in power-down; any low is taken as a real reset.
    if (!MASTER_CLEAR_PIN_N) begin
      n.dev_reset = 1'b1;
      n.cause = SWC_CAUSE_MASTER_CLEAR_PIN;
      n.st = SWC_RUN;
      n.osc_run = 1'b1;
      n.phase_run = 1'b1;
      n.pin_hold = 1'b0;
      n.vec = 1'b0;
    end else begin
      case (r.st)
        SWC_RUN: begin
          if (SLEEP_EXEC) begin
            n.prefetch = 1'b1;
            // Flags of the previous cycle decide: a flag rising now counts as during sleep.
            if (!irq_wake(r.flags_prev, r.ctrl, r.ctrl[SWC_C_EDGE_EN])) begin
              n.wdt_clear = wdt_en;
              n.pd = 1'b0;
              n.to = 1'b1;
              n.osc_run = 1'b0;
              n.phase_run = 1'b0;
              n.pin_hold = 1'b1;
              n.edge_en_lat = r.ctrl[SWC_C_EDGE_EN];
              n.st = SWC_SLEEP;
            end
          end else if (WDT_TIMEOUT && wdt_en) begin
            n.dev_reset = 1'b1;
            n.to = 1'b0;
            n.cause = SWC_CAUSE_WDT;
          end
        end
        SWC_SLEEP: begin
          if (WDT_TIMEOUT && wdt_en) begin
            n.to = 1'b0;
            n.cause = SWC_CAUSE_WDT;
            n.vec = 1'b0;
          end else if (irq_wake(flags_now, r.ctrl, r.edge_en_lat)) begin
            n.cause = SWC_CAUSE_IRQ;
            n.vec = r.ctrl[SWC_C_GIE];
          end
          if ((WDT_TIMEOUT && wdt_en) || irq_wake(flags_now, r.ctrl, r.edge_en_lat)) begin
            n.osc_run = 1'b1;
            if (is_crystal(osc_mode)) begin
              n.ost_start = 1'b1;
              n.st = SWC_OSTW;
            end else begin
              n.st = SWC_RESUME;
            end
          end
        end
        SWC_OSTW: begin
          if (ost_done) begin
            n.st = SWC_RESUME;
          end
        end
        SWC_RESUME: begin
          n.resume = 1'b1;
          n.vector_br = r.vec;
          n.vec = 1'b0;
          n.phase_run = 1'b1;
          n.pin_hold = 1'b0;
          n.st = SWC_RUN;
        end
        default: begin
          n.st = SWC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r <= '0;
      r.st <= SWC_RUN;
      r.ctrl <= SWC_CTRL_RESET;
      r.pd <= 1'b1;
      r.to <= 1'b1;
      r.osc_run <= 1'b1;
      r.phase_run <= 1'b1;
    end else begin
      r <= n;
    end
  end

  swc_startup_timer #(
    .CYCLES(OST_CYCLES)
  ) u_ost (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .start(r.ost_start),
    .done(ost_done),
    .busy(ost_busy)
  );

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign OSC_RUN = r.osc_run;
  assign PHASE_CLK_RUN = r.phase_run;
  assign PIN_HOLD = r.pin_hold;
  assign WDT_CLEAR = r.wdt_clear;
  assign DEVICE_RESET = r.dev_reset;
  assign PREFETCH_REQ = r.prefetch;
  assign RESUME_EXEC = r.resume;
  assign VECTOR_BRANCH = r.vector_br;
  assign POWER_DOWN_FLAG = r.pd;
  assign TIMEOUT_FLAG = r.to;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic in_sleep;
  logic sleep_go;
  assign in_sleep = (r.st == SWC_SLEEP);
  assign sleep_go = (r.st == SWC_RUN) && SLEEP_EXEC && MASTER_CLEAR_PIN_N;

  sequence s_sleep_entered;
    (r.st == SWC_RUN) ##1 in_sleep;
  endsequence

  sequence s_wdt_wake;
    in_sleep && MASTER_CLEAR_PIN_N && WDT_TIMEOUT && wdt_en;
  endsequence

  a_sleep_only_instr: assert property (
    s_sleep_entered |-> $past(SLEEP_EXEC))
    else $error("Power-down entered without a sleep instruction.");

  a_entry_flags_set: assert property (
    s_sleep_entered |-> !POWER_DOWN_FLAG && TIMEOUT_FLAG && !OSC_RUN && WDT_CLEAR == wdt_en)
    else $error("Sleep entry did not set flags, clear watchdog or stop oscillator.");

  a_pins_frozen: assert property (
    in_sleep |-> PIN_HOLD && !PHASE_CLK_RUN)
    else $error("Pins or phase clocks released during power-down.");

  a_pin_reset_only: assert property (
    in_sleep && !MASTER_CLEAR_PIN_N |=> DEVICE_RESET && !RESUME_EXEC && r.st == SWC_RUN)
    else $error("Reset pin in power-down did not reset the device.");

  a_wdt_wake_noreset: assert property (
    s_wdt_wake |=> !TIMEOUT_FLAG && !DEVICE_RESET && r.cause == SWC_CAUSE_WDT && !r.vec &&
    (r.st == SWC_OSTW || r.st == SWC_RESUME))
    else $error("Watchdog wake reset the device or did not head for resume.");

  a_wdt_resume_novec: assert property (
    RESUME_EXEC && r.cause == SWC_CAUSE_WDT |-> !VECTOR_BRANCH)
    else $error("Watchdog wake vectored to the interrupt routine.");

  // A counter bounds the start-up wait; a delay range that long would be slow to unroll.
  a_ost_wait_bound: assert property (
    r.ost_wait <= OST_CYCLES + 2)
    else $error("Crystal mode wake waited longer than the start-up delay.");

  a_nop_sleep: assert property (
    sleep_go && irq_wake(r.flags_prev, r.ctrl, r.ctrl[SWC_C_EDGE_EN])
    |=> PREFETCH_REQ && !WDT_CLEAR && r.st == SWC_RUN && POWER_DOWN_FLAG == $past(r.pd))
    else $error("Sleep with a pending interrupt was not a no-operation.");

  a_prefetch_next: assert property (
    sleep_go |=> PREFETCH_REQ)
    else $error("Instruction after sleep was not prefetched.");

  a_vector_irq_only: assert property (
    VECTOR_BRANCH |-> RESUME_EXEC && r.cause == SWC_CAUSE_IRQ && r.ctrl[SWC_C_GIE])
    else $error("Vector branch without an enabled interrupt wake.");

  a_rc_no_delay: assert property (
    in_sleep && MASTER_CLEAR_PIN_N && irq_wake(flags_now, r.ctrl, r.edge_en_lat) &&
    !is_crystal(osc_mode) |=> r.st == SWC_RESUME ##1 RESUME_EXEC)
    else $error("RC mode wake did not resume at once.");

  a_xtal_delay: assert property (
    $rose(r.st == SWC_OSTW) |-> (r.st == SWC_OSTW || !MASTER_CLEAR_PIN_N)[*8])
    else $error("Crystal mode wake skipped the start-up delay.");

endmodule

`default_nettype wire

// ==== verification/swc_sleep_ctrl_tb.sv ====
/*
  Self-checking bench for the sleep and wake-up controller, with a small reference model.
  Assumes the controller alone, driven at its ports, with a shortened start-up count.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import swc_pkg::*;

  localparam int OST = 8;

  logic clk, sys_rst, psel, penable, pwrite, sleep_exec, master_clear_pin_n, wdt_to;
  logic edge_f, pchg_f, ad_f, pready, pslverr, osc_run, phase_run, pin_hold;
  logic wdt_clr, dev_rst, prefetch, resume, vector, pd_flag, to_flag, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic m_pd, m_to;
  int error_cnt, cmp_count, rst_cnt, res_cnt, r0, n;

  swc_sleep_ctrl #(.OST_CYCLES(OST)) dut (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLEEP_EXEC(sleep_exec), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .WDT_TIMEOUT(wdt_to),
    .EDGE_IRQ_FLAG(edge_f), .PINCHG_IRQ_FLAG(pchg_f), .AD_IRQ_FLAG(ad_f),
    .OSC_RUN(osc_run), .PHASE_CLK_RUN(phase_run), .PIN_HOLD(pin_hold),
    .WDT_CLEAR(wdt_clr), .DEVICE_RESET(dev_rst), .PREFETCH_REQ(prefetch),
    .RESUME_EXEC(resume), .VECTOR_BRANCH(vector), .POWER_DOWN_FLAG(pd_flag),
    .TIMEOUT_FLAG(to_flag)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sampled in the active region of the edge, so the pulse of the ending cycle is seen.
  always @(posedge clk) begin
    if (dev_rst === 1'b1) rst_cnt++;
    if (resume === 1'b1) res_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo;
    error_cnt++;
    give_verdict();
  endtask

  // Pready, read data and error are read just after the rising edge, before it updates them.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_sleep(input logic [31:0] c, input bit noop, input bit dur);
    @(posedge clk);
    sleep_exec <= 1'b1;
    if (dur) edge_f <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    @(negedge clk);
    if (!noop) begin
      m_pd = 1'b0;
      m_to = 1'b1;
    end
    chk(prefetch, 1'b1);
    chk(wdt_clr, noop ? 1'b0 : c[SWC_C_WDT_EN]);
    chk({osc_run, phase_run, pin_hold}, noop ? 3'b110 : 3'b001);
    chk({pd_flag, to_flag}, {m_pd, m_to});
  endtask

  task automatic raise(input int s);
    @(posedge clk);
    case (s)
      0: edge_f <= 1'b1;
      1: pchg_f <= 1'b1;
      2: ad_f <= 1'b1;
      default: wdt_to <= 1'b1;
    endcase
    @(posedge clk);
    wdt_to <= 1'b0;
  endtask

  task automatic clear_all;
    @(posedge clk);
    edge_f <= 1'b0;
    pchg_f <= 1'b0;
    ad_f <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_res(input int mx, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (resume !== 1'b1 && k < mx);
    if (resume !== 1'b1) tmo();
  endtask

  // One wake-up by source s (edge, pin change, A/D on RC clock, watchdog) in one mode.
  task automatic wake(input int mode, input int s);
    logic [31:0] c;
    logic g;
    int k, r;
    g = 1'($urandom_range(0, 1));
    c = 32'(mode) << SWC_C_OSC_LSB;
    c[SWC_C_GIE] = g;
    c[SWC_C_WDT_EN] = (s == 3) ? 1'b1 : 1'($urandom_range(0, 1));
    c[SWC_C_EDGE_EN + s] = (s < 3);
    c[SWC_C_AD_RC] = (s == 2);
    apb(1'b1, SWC_CTRL_OFS, c);
    apb(1'b0, SWC_CTRL_OFS, 32'h0);
    chk(rd, c);
    r = rst_cnt;
    do_sleep(c, 1'b0, 1'b0);
    apb(1'b0, SWC_STATUS_OFS, 32'h0);
    chk({rd[SWC_S_TO], rd[SWC_S_PD], rd[SWC_S_ASLEEP]}, {m_to, m_pd, 1'b1});
    repeat ($urandom_range(0, 5)) @(posedge clk);
    raise(s);
    wait_res(OST + 12, k);
    chk(mode >= 2 ? (k >= OST && k <= OST + 6) : (k <= 4), 1'b1);
    chk(vector, g && s != 3);
    if (s == 3) m_to = 1'b0;
    chk({osc_run, phase_run, pin_hold}, 3'b110);
    chk({pd_flag, to_flag}, {m_pd, m_to});
    chk(rst_cnt - r, 0);
    clear_all();
  endtask

  // A cause that must not wake; the reset pin then ends power-down with a full reset.
  task automatic no_wake(input logic [31:0] c, input int s);
    int r;
    apb(1'b1, SWC_CTRL_OFS, c);
    do_sleep(c, 1'b0, 1'b0);
    r = res_cnt;
    raise(s);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(res_cnt - r, 0);
    chk({phase_run, pin_hold}, 2'b01);
    r = rst_cnt;
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    @(posedge clk);
    master_clear_pin_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(rst_cnt - r, 1);
    chk({osc_run, phase_run, pin_hold, pd_flag, to_flag}, {3'b110, m_pd, m_to});
    clear_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, psel, penable, pwrite, sleep_exec, wdt_to, edge_f, pchg_f, ad_f} = 9'h100;
    master_clear_pin_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    {error_cnt, cmp_count, rst_cnt, res_cnt} = '0;
    m_pd = 1'b1;
    m_to = 1'b1;
    void'($urandom(32'h15a41d46));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({osc_run, phase_run, pin_hold, pd_flag, to_flag}, 5'h1b);
    apb(1'b0, 8'h08, 32'h0);
    chk({err, rd[0]}, 2'b10);
    apb(1'b1, SWC_STATUS_OFS, 32'h0);
    apb(1'b0, SWC_STATUS_OFS, 32'h0);
    chk(rd[SWC_S_PD], 1'b1);
    // A watchdog run-out while running resets and clears the time-out flag.
    apb(1'b1, SWC_CTRL_OFS, 32'h1);
    r0 = rst_cnt;
    raise(3);
    repeat (2) @(posedge clk);
    @(negedge clk);
    m_to = 1'b0;
    chk({rst_cnt - r0 == 1, to_flag}, 2'b10);
    // With the flag already high, sleep must leave both flags alone.
    apb(1'b1, SWC_CTRL_OFS, 32'h4);
    @(posedge clk);
    edge_f <= 1'b1;
    repeat (2) @(posedge clk);
    do_sleep(32'h4, 1'b1, 1'b0);
    clear_all();
    // Flag rising with the sleep pulse: sleep completes, then wakes at once.
    do_sleep(32'h4, 1'b0, 1'b1);
    wait_res(10, n);
    chk(vector, 1'b0);
    clear_all();
    for (int m = 0; m < 5; m++) begin
      for (int s = 0; s < 4; s++) wake(m, s);
    end
    no_wake(32'h2, 0);
    no_wake(32'h10, 2);
    no_wake(32'h0, 3);
    give_verdict();
  end
endmodule

`default_nettype wire
